// >>> common/dcpc_pkg.sv
package dcpc_pkg;
  // register addresses
  localparam logic [4:0] ADDR_POWER = 5'h00;
  localparam logic [4:0] ADDR_FORMAT = 5'h02;
  localparam logic [4:0] ADDR_DELAY = 5'h03;
  localparam logic [4:0] ADDR_PLL = 5'h08;
  localparam logic [4:0] ADDR_AUX1_LO = 5'h0c;
  localparam logic [4:0] ADDR_AUX1_CTL = 5'h0d;
  localparam logic [4:0] ADDR_AUX2_LO = 5'h10;
  localparam logic [4:0] ADDR_AUX2_CTL = 5'h11;
  localparam logic [7:0] REG_RST = 8'h00;
  // power and mode fields
  localparam int PWR_DAC_PD_BIT = 7;
  localparam int PWR_DAC_SLEEP_BIT = 6;
  localparam int PWR_AUX_PD_BIT = 5;
  localparam int PWR_DIG_PD_BIT = 4;
  localparam int PWR_AUX_SLEEP_BIT = 3;
  localparam int PWR_ALL_PD_BIT = 2;
  // format, delay and pll fields
  localparam int FMT_DCLK_INV_BIT = 2;
  localparam int DLY_LSB = 3;
  localparam int PLL_EN_BIT = 7;
  localparam int PLL_VCO_DIV_LSB = 4;
  localparam int PLL_REF_DIV_LSB = 2;
  localparam int PLL_INTERP_LSB = 0;
  // aux control fields
  localparam int AUX_OFF_BIT = 7;
  localparam int AUX_SINK_BIT = 6;
  localparam int AUX_INV_BIT = 5;
  localparam logic [9:0] AUX_CODE_MAX = 10'h3ff;
  // serial port
  localparam int SPI_RW_BIT = 7;
  localparam logic [2:0] SPI_LAST_BIT = 3'h7;
  typedef enum logic [1:0] {SPI_IDLE, SPI_INSTR, SPI_DATA} dcpc_spi_state_t;
endpackage

// >>> logic/dcpc_top.sv
`timescale 1ns/1ps
module dcpc_top (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // serial register port
  input wire logic spi_sclk_i,
  input wire logic spi_csn_i,
  input wire logic spi_sdi_i,
  output logic spi_sdo_o,
  output logic spi_sdo_oe_o,
  // transmit control and sample data
  input wire logic transmit_enable_pin_i,
  input wire logic [13:0] sample_i,
  output logic [13:0] sample_o,
  output logic data_clock_output_o,
  output logic [2:0] data_clock_delay_o,
  // clock tree control
  output logic pll_enable_o,
  output logic [1:0] vco_divider_o,
  output logic [1:0] reference_ratio_divider_o,
  output logic [1:0] interpolation_divider_o,
  // power control
  output logic digital_power_down_o,
  output logic converter_sleep_o,
  output logic converter_power_down_o,
  output logic bandgap_power_down_o,
  output logic aux_sleep_o,
  output logic aux_power_down_o,
  // auxiliary converters
  output logic [9:0] aux1_code_o,
  output logic aux1_off_o,
  output logic aux1_sink_o,
  output logic [9:0] aux2_code_o,
  output logic aux2_off_o,
  output logic aux2_sink_o
);

  // map an address onto a register slot; bit 3 flags a hit
  function automatic logic [3:0] slot_of(input logic [4:0] addr);
    case (addr)
      dcpc_pkg::ADDR_POWER: slot_of = 4'h8;
      dcpc_pkg::ADDR_FORMAT: slot_of = 4'h9;
      dcpc_pkg::ADDR_DELAY: slot_of = 4'ha;
      dcpc_pkg::ADDR_PLL: slot_of = 4'hb;
      dcpc_pkg::ADDR_AUX1_LO: slot_of = 4'hc;
      dcpc_pkg::ADDR_AUX1_CTL: slot_of = 4'hd;
      dcpc_pkg::ADDR_AUX2_LO: slot_of = 4'he;
      dcpc_pkg::ADDR_AUX2_CTL: slot_of = 4'hf;
      default: slot_of = 4'h0;
    endcase
  endfunction

  // aux code with optional scale reversal
  function automatic logic [9:0] aux_code(input logic [7:0] lo, input logic [7:0] ctl);
    logic [9:0] gain;
    gain = {ctl[1:0], lo};
    aux_code = ctl[dcpc_pkg::AUX_INV_BIT] ? dcpc_pkg::AUX_CODE_MAX - gain : gain;
  endfunction

  logic [7:0] regs_reg [0:7];
  logic sclk_meta, sclk_sync, sclk_prev;
  logic csn_meta, csn_sync;
  logic sdi_meta, sdi_sync;
  logic tx_meta, tx_sync;
  logic [13:0] data_meta, data_sync;
  dcpc_pkg::dcpc_spi_state_t spi_state_reg;
  logic [2:0] bit_cnt_reg;
  logic [6:0] shift_reg;
  logic [4:0] addr_reg;
  logic read_reg;
  logic [7:0] out_reg;
  logic sclk_rise, sclk_fall, wr_stb;
  logic [3:0] rd_slot, wr_slot;
  logic [7:0] rd_data;
  logic [2:0] div_cnt_reg;
  logic [2:0] div_last, div_half;
  logic dclk_reg, capture;
  logic [13:0] sample_reg;
  logic pwr_all, flush;

  // pin synchronisers, two flops each
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      sclk_meta <= 1'b0;
      sclk_sync <= 1'b0;
      sclk_prev <= 1'b0;
      csn_meta <= 1'b1;
      csn_sync <= 1'b1;
      sdi_meta <= 1'b0;
      sdi_sync <= 1'b0;
      tx_meta <= 1'b0;
      tx_sync <= 1'b0;
      data_meta <= 14'h0000;
      data_sync <= 14'h0000;
    end
    else
    begin
      sclk_meta <= spi_sclk_i;
      sclk_sync <= sclk_meta;
      sclk_prev <= sclk_sync;
      csn_meta <= spi_csn_i;
      csn_sync <= csn_meta;
      sdi_meta <= spi_sdi_i;
      sdi_sync <= sdi_meta;
      tx_meta <= transmit_enable_pin_i;
      tx_sync <= tx_meta;
      data_meta <= sample_i;
      data_sync <= data_meta;
    end
  end

  // serial clock edges inside a selected frame
  assign sclk_rise = sclk_sync & ~sclk_prev & ~csn_sync;
  assign sclk_fall = ~sclk_sync & sclk_prev & ~csn_sync;
  assign wr_stb = (spi_state_reg == dcpc_pkg::SPI_DATA) & sclk_rise & ~read_reg
    & (bit_cnt_reg == dcpc_pkg::SPI_LAST_BIT);
  assign rd_slot = slot_of({shift_reg[3:0], sdi_sync});
  // slot of the address latched for the data byte
  assign wr_slot = slot_of(addr_reg);
  assign rd_data = rd_slot[3] ? regs_reg[rd_slot[2:0]] : 8'h00;

  // instruction byte then one data byte, msb first
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      spi_state_reg <= dcpc_pkg::SPI_IDLE;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 7'h00;
      addr_reg <= 5'h00;
      read_reg <= 1'b0;
      out_reg <= 8'h00;
    end
    else if (csn_sync)
    begin
      spi_state_reg <= dcpc_pkg::SPI_IDLE;
      bit_cnt_reg <= 3'h0;
      read_reg <= 1'b0;
    end
    else
    begin
      case (spi_state_reg)
        dcpc_pkg::SPI_IDLE:
        begin
          spi_state_reg <= dcpc_pkg::SPI_INSTR;
          bit_cnt_reg <= 3'h0;
        end
        dcpc_pkg::SPI_INSTR:
        begin
          if (sclk_rise)
          begin
            shift_reg <= {shift_reg[5:0], sdi_sync};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == dcpc_pkg::SPI_LAST_BIT)
            begin
              spi_state_reg <= dcpc_pkg::SPI_DATA;
              read_reg <= shift_reg[dcpc_pkg::SPI_RW_BIT - 1];
              addr_reg <= {shift_reg[3:0], sdi_sync};
              out_reg <= rd_data; // unmapped reads zero
            end
          end
        end
        dcpc_pkg::SPI_DATA:
        begin
          if (sclk_rise)
          begin
            shift_reg <= {shift_reg[5:0], sdi_sync};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == dcpc_pkg::SPI_LAST_BIT)
            begin
              spi_state_reg <= dcpc_pkg::SPI_INSTR;
              read_reg <= 1'b0;
            end
          end
          else if (sclk_fall && bit_cnt_reg != 3'h0)
            out_reg <= {out_reg[6:0], 1'b0};
        end
        default: spi_state_reg <= dcpc_pkg::SPI_IDLE;
      endcase
    end
  end

  assign spi_sdo_o = out_reg[7];
  assign spi_sdo_oe_o = (spi_state_reg == dcpc_pkg::SPI_DATA) & read_reg;

  // register file, written at the last data bit
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < 8; i++)
        regs_reg[i] <= dcpc_pkg::REG_RST;
    end
    else if (wr_stb && wr_slot[3])
      regs_reg[wr_slot[2:0]] <= {shift_reg, sdi_sync};
  end

  // power decode
  assign pwr_all = regs_reg[0][dcpc_pkg::PWR_ALL_PD_BIT];
  assign flush = ~tx_sync & ~regs_reg[0][dcpc_pkg::PWR_DIG_PD_BIT] & ~pwr_all;
  assign digital_power_down_o = pwr_all
    | (~tx_sync & regs_reg[0][dcpc_pkg::PWR_DIG_PD_BIT]);
  assign converter_sleep_o = regs_reg[0][dcpc_pkg::PWR_DAC_SLEEP_BIT];
  assign converter_power_down_o = regs_reg[0][dcpc_pkg::PWR_DAC_PD_BIT] | pwr_all;
  assign bandgap_power_down_o = converter_power_down_o;
  assign aux_sleep_o = regs_reg[0][dcpc_pkg::PWR_AUX_SLEEP_BIT];
  assign aux_power_down_o = regs_reg[0][dcpc_pkg::PWR_AUX_PD_BIT] | pwr_all;

  // clock tree selections
  assign pll_enable_o = regs_reg[3][dcpc_pkg::PLL_EN_BIT];
  assign vco_divider_o = regs_reg[3][dcpc_pkg::PLL_VCO_DIV_LSB +: 2];
  assign reference_ratio_divider_o = regs_reg[3][dcpc_pkg::PLL_REF_DIV_LSB +: 2];
  assign interpolation_divider_o = regs_reg[3][dcpc_pkg::PLL_INTERP_LSB +: 2];
  assign data_clock_delay_o = regs_reg[2][dcpc_pkg::DLY_LSB +: 3];

  // auxiliary converters
  assign aux1_code_o = aux_code(regs_reg[4], regs_reg[5]);
  assign aux1_off_o = regs_reg[5][dcpc_pkg::AUX_OFF_BIT] | aux_power_down_o;
  assign aux1_sink_o = regs_reg[5][dcpc_pkg::AUX_SINK_BIT];
  assign aux2_code_o = aux_code(regs_reg[6], regs_reg[7]);
  assign aux2_off_o = regs_reg[7][dcpc_pkg::AUX_OFF_BIT] | aux_power_down_o;
  assign aux2_sink_o = regs_reg[7][dcpc_pkg::AUX_SINK_BIT];

  // data clock period of 2, 4 or 8 converter cycles
  assign div_last = (interpolation_divider_o == 2'h3) ? 3'h7
    : (interpolation_divider_o == 2'h2) ? 3'h3 : 3'h1;
  assign div_half = div_last >> 1;
  assign capture = (div_cnt_reg == div_half);

  // divider derived from the reference clock
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      div_cnt_reg <= 3'h0;
      dclk_reg <= 1'b0;
    end
    else
    begin
      div_cnt_reg <= (div_cnt_reg >= div_last) ? 3'h0 : div_cnt_reg + 3'h1;
      dclk_reg <= (div_cnt_reg >= div_half) && (div_cnt_reg < div_last);
    end
  end

  assign data_clock_output_o = dclk_reg ^ regs_reg[1][dcpc_pkg::FMT_DCLK_INV_BIT];

  // sample capture on the same clock edge that raises the data clock
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      sample_reg <= 14'h0000;
    else if (capture)
    begin
      if (flush)
        sample_reg <= 14'h0000;
      else if (!digital_power_down_o)
        sample_reg <= data_sync;
    end
  end

  assign sample_o = sample_reg;

  // checks
  sequence s_flush_capture;
    capture && flush;
  endsequence

  property p_flush;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    s_flush_capture |=> (sample_o == 14'h0000);
  endproperty
  a_flush: assert property (p_flush)
    else $error("flush did not zero sample");

  property p_dig_pd_hold;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    digital_power_down_o |=> $stable(sample_o) || !$past(digital_power_down_o);
  endproperty
  a_dig_pd_hold: assert property (p_dig_pd_hold)
    else $error("sample moved in digital power down");

  property p_dig_pd_only;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (!tx_sync && regs_reg[0][dcpc_pkg::PWR_DIG_PD_BIT] && !pwr_all)
      |-> digital_power_down_o && (bandgap_power_down_o
      == regs_reg[0][dcpc_pkg::PWR_DAC_PD_BIT]);
  endproperty
  a_dig_pd_only: assert property (p_dig_pd_only)
    else $error("digital power down disturbed converters");

  property p_tx_normal;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (tx_sync && !pwr_all) |-> !digital_power_down_o && !flush;
  endproperty
  a_tx_normal: assert property (p_tx_normal)
    else $error("enable high did not run normally");

  property p_sleep_ref;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (converter_sleep_o && !converter_power_down_o) |-> !bandgap_power_down_o;
  endproperty
  a_sleep_ref: assert property (p_sleep_ref)
    else $error("sleep turned reference off");

  property p_pd_ref;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    converter_power_down_o |-> bandgap_power_down_o;
  endproperty
  a_pd_ref: assert property (p_pd_ref)
    else $error("power down left reference on");

  property p_all_pd;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    pwr_all |-> digital_power_down_o && converter_power_down_o && aux_power_down_o;
  endproperty
  a_all_pd: assert property (p_all_pd)
    else $error("global power down incomplete");

  property p_aux_inv;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    regs_reg[5][dcpc_pkg::AUX_INV_BIT]
      |-> (aux1_code_o + {regs_reg[5][1:0], regs_reg[4]} == dcpc_pkg::AUX_CODE_MAX);
  endproperty
  a_aux_inv: assert property (p_aux_inv)
    else $error("aux scale not reversed");

  property p_capture_edge;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    capture && $stable(interpolation_divider_o) |=> $rose(dclk_reg);
  endproperty
  a_capture_edge: assert property (p_capture_edge)
    else $error("capture not before data clock rise");

  property p_dclk_period;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    ($rose(dclk_reg) && $stable(interpolation_divider_o)
      && interpolation_divider_o == 2'h2)
      ##1 (interpolation_divider_o == 2'h2) [*3] |=> $rose(dclk_reg);
  endproperty
  a_dclk_period: assert property (p_dclk_period)
    else $error("data clock period wrong");

  property p_pll_sel;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    wr_stb && addr_reg == dcpc_pkg::ADDR_PLL
      |=> pll_enable_o == $past(shift_reg[dcpc_pkg::PLL_EN_BIT - 1]);
  endproperty
  a_pll_sel: assert property (p_pll_sel)
    else $error("pll enable not taken from write");

endmodule

// >>> logic/dcpc_notes_unused.sv
`timescale 1ns/1ps

// >>> testbench/dcpc_host.sv
`timescale 1ns/1ps
// host side: serial register master and sample source
module dcpc_host (
  // clock
  input wire logic ref_clk_i,
  // serial port
  input wire logic spi_sdo_i,
  output logic spi_sclk_o,
  output logic spi_csn_o,
  output logic spi_sdi_o,
  // sample data
  output logic [13:0] sample_o
);
  // idle levels at time zero
  initial
  begin
    spi_sclk_o = 1'b0;
    spi_csn_o = 1'b1;
    spi_sdi_o = 1'b0;
    sample_o = 14'h0000;
  end
  // one frame: instruction then data, msb first, 5 clocks a phase
  task automatic xfer(input logic [7:0] ins, input logic [7:0] dat, output logic [7:0] rd);
    @(negedge ref_clk_i) spi_csn_o = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      spi_sdi_o = (i > 7) ? ins[i-8] : dat[i];
      repeat (5) @(negedge ref_clk_i);
      spi_sclk_o = 1'b1;
      if (i < 8) rd[i] = spi_sdo_i;
      repeat (5) @(negedge ref_clk_i);
      spi_sclk_o = 1'b0;
    end
    // let the write land before the frame closes
    repeat (8) @(negedge ref_clk_i);
    spi_csn_o = 1'b1;
    spi_sdi_o = ~spi_sdi_o;
    repeat (4) @(negedge ref_clk_i);
  endtask
  // new sample, changed off the capturing edge
  task automatic put(input logic [13:0] v);
    @(negedge ref_clk_i) sample_o = v;
  endtask
endmodule

// >>> testbench/dac_clock_power_control_bench.sv
`timescale 1ns/1ps
module dac_clock_power_control_bench;
  logic ref_clk_i, rstn_i, sclk, csn, sdi, sdo, sdo_oe, tx;
  logic [13:0] smp_in, smp_out;
  logic dclk, pll_en, dpd, slp, cpd, bpd, asl, apd, a1_off, a1_sink, a2_off, a2_sink;
  logic [2:0] dly;
  logic [1:0] vdiv, rdiv, idiv;
  logic [9:0] a1_code, a2_code;
  logic [7:0] pw;
  logic dclk_q, oe_seen;
  int run, gap, bad_count, check_count;
  localparam logic [4:0] ADDRS [8] = '{5'h00, 5'h02, 5'h03, 5'h08, 5'h0c, 5'h0d, 5'h10, 5'h11};
  localparam logic [7:0] PV [6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04};
  localparam logic [7:0] PE [6] = '{8'h0c, 8'h10, 8'hc1, 8'h00, 8'h02, 8'hed};
  localparam logic [15:0] PD [4] = '{16'h2, 16'h2, 16'h4, 16'h8};
  localparam logic [7:0] AC [3] = '{8'h02, 8'h22, 8'hc0};
  localparam logic [15:0] AE [3] = '{16'h025a, 16'h01a5, 16'h0c5a};
  // power outputs gathered for one compare
  assign pw = {a2_off, a1_off, dpd, slp, cpd, bpd, asl, apd};
  // converter-rate clock, four times the data clock rate for bypass
  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  dcpc_top u_dcpc_top (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .spi_sclk_i(sclk),
    .spi_csn_i(csn), .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe),
    .transmit_enable_pin_i(tx), .sample_i(smp_in), .sample_o(smp_out),
    .data_clock_output_o(dclk), .data_clock_delay_o(dly), .pll_enable_o(pll_en),
    .vco_divider_o(vdiv), .reference_ratio_divider_o(rdiv),
    .interpolation_divider_o(idiv), .digital_power_down_o(dpd), .converter_sleep_o(slp),
    .converter_power_down_o(cpd), .bandgap_power_down_o(bpd), .aux_sleep_o(asl),
    .aux_power_down_o(apd), .aux1_code_o(a1_code), .aux1_off_o(a1_off),
    .aux1_sink_o(a1_sink), .aux2_code_o(a2_code), .aux2_off_o(a2_off),
    .aux2_sink_o(a2_sink));
  dcpc_host u_dcpc_host (.ref_clk_i(ref_clk_i), .spi_sdo_i(sdo), .spi_sclk_o(sclk),
    .spi_csn_o(csn), .spi_sdi_o(sdi), .sample_o(smp_in));
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] r;
    u_dcpc_host.xfer({3'h0, a}, d, r);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] r;
    u_dcpc_host.xfer({3'h4, a}, 8'h00, r);
    check(16'(r), 16'(e));
  endtask
  // new sample must show as the data clock takes its active edge
  task automatic cap(input logic inv, input logic [13:0] v);
    int n;
    n = 0;
    u_dcpc_host.put(v);
    while (smp_out !== v && n < 40)
    begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    check(16'(smp_out), 16'(v));
    check(16'(dclk), {15'h0000, ~inv});
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // data clock rise-to-rise spacing in clocks
  always @(negedge ref_clk_i)
  begin
    dclk_q <= dclk;
    run <= (dclk & !dclk_q) ? 1 : run + 1;
    if (dclk & !dclk_q) gap <= run;
  end
  // remembers that the read port drove its data line
  always @(negedge ref_clk_i)
    oe_seen <= rstn_i && (oe_seen || sdo_oe);
  // hang guard, well past the expected run
  initial
  begin
    repeat (40000) @(posedge ref_clk_i);
    bad_count++;
    conclude();
  end
  initial
  begin
    rstn_i = 1'b0;
    tx = 1'b1;
    bad_count = 0;
    check_count = 0;
    repeat (6) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    repeat (6) @(negedge ref_clk_i);
    // registers and outputs start at zero
    foreach (ADDRS[i]) rd(ADDRS[i], 8'h00);
    check(16'(pw), 16'h0000);
    check(16'(oe_seen), 16'h0001);
    check(16'(sdo_oe), 16'h0000);
    // read back every register, unmapped place reads zero
    foreach (ADDRS[i])
    begin
      wr(ADDRS[i], 8'ha5);
      rd(ADDRS[i], 8'ha5);
      wr(ADDRS[i], 8'h00);
    end
    wr(5'h05, 8'hff);
    rd(5'h05, 8'h00);
    $display("test registers done");
    // each power bit alone
    foreach (PV[k])
    begin
      wr(dcpc_pkg::ADDR_POWER, PV[k]);
      check(16'(pw), 16'(PE[k]));
    end
    wr(dcpc_pkg::ADDR_POWER, 8'h00);
    $display("test power done");
    // transmit enable against the digital power down bit
    u_dcpc_host.put(14'h1234);
    @(negedge ref_clk_i) tx = 1'b0;
    repeat (20) @(negedge ref_clk_i);
    check(16'(smp_out), 16'h0000);
    check(16'(pw), 16'h0000);
    wr(dcpc_pkg::ADDR_POWER, 8'h10);
    check(16'(pw), 16'h0020);
    @(negedge ref_clk_i) tx = 1'b1;
    repeat (20) @(negedge ref_clk_i);
    check(16'(smp_out), 16'h1234);
    check(16'(pw), 16'h0000);
    wr(dcpc_pkg::ADDR_POWER, 8'h00);
    $display("test transmit done");
    // pll path with every interpolation code, then bypass
    foreach (PD[c])
    begin
      wr(dcpc_pkg::ADDR_PLL, 8'hb4 | 8'(c));
      repeat (40) @(negedge ref_clk_i);
      check(16'(gap), PD[c]);
      check(16'({pll_en, vdiv, rdiv, idiv}), 16'({5'h1d, 2'(c)}));
    end
    wr(dcpc_pkg::ADDR_PLL, 8'h36);
    check(16'({pll_en, idiv}), 16'h0002);
    cap(1'b0, 14'h0abc);
    wr(dcpc_pkg::ADDR_FORMAT, 8'h04);
    cap(1'b1, 14'h1555);
    wr(dcpc_pkg::ADDR_DELAY, 8'h38);
    check(16'(dly), 16'h0007);
    wr(dcpc_pkg::ADDR_DELAY, 8'h08);
    check(16'(dly), 16'h0001);
    $display("test clocking done");
    // both aux converters: gain, invert, off and sink
    for (int n = 0; n < 2; n++)
    begin
      wr(n ? dcpc_pkg::ADDR_AUX2_LO : dcpc_pkg::ADDR_AUX1_LO, 8'h5a);
      foreach (AC[j])
      begin
        wr(n ? dcpc_pkg::ADDR_AUX2_CTL : dcpc_pkg::ADDR_AUX1_CTL, AC[j]);
        check(n ? {4'h0, a2_off, a2_sink, a2_code} : {4'h0, a1_off, a1_sink, a1_code},
          AE[j]);
      end
    end
    $display("test aux done");
    conclude();
  end
endmodule
